/* design/relay_threshold_control.sv */
/*
 * Relay threshold controller with AXI4-Lite register slave.
 * Assumes measured values and serial events come from logic on clk.
 */
`timescale 1ns/1ns
module relay_threshold_control import relay_pkg::*; #(
  parameter int TENTH_SEC_CYC = TENTH_SEC_CYCLES,
  parameter int TENTH_MIN_CYC = TENTH_MIN_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic signed [15:0] live_value,
  input wire logic signed [15:0] peak_value,
  input wire logic value_over_range,
  input wire logic serial_rx_pulse,
  input wire logic serial_cmd_valid,
  input wire logic serial_cmd_on,
  output logic relay_on,
  output logic led_on
);

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= STATUS_OFS);
  endfunction : mapped

  function automatic logic signed [17:0] sx(input logic signed [15:0] v);
    return {{2{v[15]}}, v};
  endfunction : sx

  relay_cfg_t cfg_q, cfg_d;
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d, bvalid_q, bvalid_d;
  logic [7:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic relay_q, relay_d, cmd_q, cmd_d;
  logic [25:0] tick_cnt_q, tick_cnt_d;
  logic [9:0] dly_cnt_q, dly_cnt_d;
  logic [15:0] silence_q, silence_d;
  logic tick, sec_tick, critical, pending, want, hold_band;
  logic signed [17:0] val, t1, t2, hi, lo, hw;
  logic [31:0] old_word, new_word, status_word;
  logic signed [15:0] thr_in;
  logic [9:0] ten_in;

  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign relay_on = relay_q;
  assign led_on = relay_q;

  assign status_word = {28'h0000000, cmd_q, pending, critical, relay_q};

  // Register file and AXI4-Lite handshakes
  always_comb begin
    aw_hold_d = aw_hold_q;
    aw_addr_d = aw_addr_q;
    w_hold_d = w_hold_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    cfg_d = cfg_q;
    old_word = 32'h00000000;
    case (aw_addr_q)
      CTRL_OFS: old_word = {25'h0000000, cfg_q.relay_one_value_source, cfg_q.unit_minutes, cfg_q.fault_response,
                            cfg_q.mode};
      THR1_OFS: old_word = {{16{cfg_q.first_threshold[15]}}, cfg_q.first_threshold};
      THR2_OFS: old_word = {{16{cfg_q.second_threshold[15]}}, cfg_q.second_threshold};
      HALF_OFS: old_word = {22'h000000, cfg_q.band_half_width};
      TON_OFS: old_word = {22'h000000, cfg_q.turn_on_delay};
      TURN_OFF_DELAY_OFS: old_word = {22'h000000, cfg_q.turn_off_delay};
      TIMEOUT_OFS: old_word = {16'h0000, cfg_q.serial_receive_timeout};
      default: old_word = 32'h00000000;
    endcase
    new_word = merge_bytes(old_word, w_data_q, w_strb_q);
    // Out-of-range values saturate so the comparators never see illegal settings
    if ($signed(new_word) < $signed({{16{THR_MIN[15]}}, THR_MIN})) begin
      thr_in = THR_MIN;
    end else if ($signed(new_word) > $signed({16'h0000, THR_MAX})) begin
      thr_in = THR_MAX;
    end else begin
      thr_in = new_word[15:0];
    end
    ten_in = (new_word > {22'h000000, DELAY_MAX}) ? DELAY_MAX : new_word[9:0];
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (aw_hold_q && w_hold_q) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      case (aw_addr_q)
        CTRL_OFS: begin
          if (new_word[2:0] <= 3'b101) begin
            cfg_d.mode = relay_mode_t'(new_word[CTRL_MODE_LSB +: 3]);
          end
          if (new_word[4:3] != 2'b11) begin
            cfg_d.fault_response = fault_resp_t'(new_word[CTRL_FAULT_LSB +: 2]);
          end
          cfg_d.unit_minutes = new_word[CTRL_UNIT_BIT];
          cfg_d.relay_one_value_source = new_word[CTRL_SRC_BIT];
        end
        THR1_OFS: cfg_d.first_threshold = thr_in;
        THR2_OFS: cfg_d.second_threshold = thr_in;
        HALF_OFS: cfg_d.band_half_width = ten_in;
        TON_OFS: cfg_d.turn_on_delay = ten_in;
        TURN_OFF_DELAY_OFS: cfg_d.turn_off_delay = ten_in;
        TIMEOUT_OFS: cfg_d.serial_receive_timeout = new_word[15:0];
        default: cfg_d = cfg_q;
      endcase
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        CTRL_OFS: rdata_d = {25'h0000000, cfg_q.relay_one_value_source, cfg_q.unit_minutes, cfg_q.fault_response,
                             cfg_q.mode};
        THR1_OFS: rdata_d = {{16{cfg_q.first_threshold[15]}}, cfg_q.first_threshold};
        THR2_OFS: rdata_d = {{16{cfg_q.second_threshold[15]}}, cfg_q.second_threshold};
        HALF_OFS: rdata_d = {22'h000000, cfg_q.band_half_width};
        TON_OFS: rdata_d = {22'h000000, cfg_q.turn_on_delay};
        TURN_OFF_DELAY_OFS: rdata_d = {22'h000000, cfg_q.turn_off_delay};
        TIMEOUT_OFS: rdata_d = {16'h0000, cfg_q.serial_receive_timeout};
        STATUS_OFS: rdata_d = status_word;
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q <= CFG_RESET;
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_hold_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else begin
      cfg_q <= cfg_d;
      aw_hold_q <= aw_hold_d;
      aw_addr_q <= aw_addr_d;
      w_hold_q <= w_hold_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // Threshold decision with hysteresis
  always_comb begin
    val = sx(cfg_q.relay_one_value_source ? peak_value : live_value);
    t1 = sx(cfg_q.first_threshold);
    t2 = sx(cfg_q.second_threshold);
    hw = {8'h00, cfg_q.band_half_width};
    hi = (t1 > t2) ? t1 : t2;
    lo = (t1 > t2) ? t2 : t1;
    want = relay_q;
    hold_band = 1'b0;
    case (cfg_q.mode)
      MODE_NORMAL: begin
        if (val > t1 + hw) want = 1'b1;
        else if (val < t1 - hw) want = 1'b0;
        else hold_band = 1'b1;
      end
      MODE_INVERTED: begin
        if (val > t1 + hw) want = 1'b0;
        else if (val < t1 - hw) want = 1'b1;
        else hold_band = 1'b1;
      end
      MODE_INSIDE: begin
        if (val > lo + hw && val < hi - hw) want = 1'b1;
        else if (val < lo - hw || val > hi + hw) want = 1'b0;
        else hold_band = 1'b1;
      end
      MODE_OUTSIDE: begin
        if (val > hi + hw || val < lo - hw) want = 1'b1;
        else if (val > lo + hw && val < hi - hw) want = 1'b0;
        else hold_band = 1'b1;
      end
      MODE_BUS: want = cmd_q;
      default: want = 1'b0;
    endcase
  end

  assign critical = (cfg_q.mode == MODE_BUS) ? (silence_q > cfg_q.serial_receive_timeout)
                                             : value_over_range;
  assign pending = (cfg_q.mode != MODE_BUS) && (cfg_q.mode != output_disabled) && (want != relay_q);
  assign tick = (tick_cnt_q == 26'h0000000);

  // Relay state, delays and serial supervision
  always_comb begin
    relay_d = relay_q;
    cmd_d = serial_cmd_valid ? serial_cmd_on : cmd_q;
    // Tick period follows the unit bit; both delays share it
    // Tick phase runs free, so a delay of N lasts N-1 to N ticks
    if (tick) begin
      tick_cnt_d = cfg_q.unit_minutes ? 26'(TENTH_MIN_CYC - 1) : 26'(TENTH_SEC_CYC - 1);
    end else begin
      tick_cnt_d = tick_cnt_q - 26'h0000001;
    end
    // Serial silence is timed in tenths of a second and stops counting while the unit bit selects minutes
    sec_tick = (tick_cnt_q == 26'h0000000) && !cfg_q.unit_minutes;
    if (serial_rx_pulse) begin
      silence_d = 16'h0000;
    end else if (sec_tick && silence_q != 16'hFFFF) begin
      silence_d = silence_q + 16'h0001;
    end else begin
      silence_d = silence_q;
    end
    dly_cnt_d = dly_cnt_q;
    if (!pending) begin
      dly_cnt_d = 10'h000;
    end else if (tick && dly_cnt_q != 10'h3FF) begin
      dly_cnt_d = dly_cnt_q + 10'h001;
    end
    if (critical) begin
      case (cfg_q.fault_response)
        FAULT_FORCE_ON: relay_d = 1'b1;
        FAULT_FORCE_OFF: relay_d = 1'b0;
        default: relay_d = relay_q;
      endcase
      dly_cnt_d = 10'h000;
    end else if (cfg_q.mode == MODE_BUS) begin
      relay_d = cmd_q;
    end else if (cfg_q.mode == output_disabled) begin
      relay_d = 1'b0;
    end else if (pending && want && dly_cnt_q >= cfg_q.turn_on_delay) begin
      relay_d = 1'b1;
      dly_cnt_d = 10'h000;
    end else if (pending && !want && dly_cnt_q >= cfg_q.turn_off_delay) begin
      relay_d = 1'b0;
      dly_cnt_d = 10'h000;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      relay_q <= 1'b0;
      cmd_q <= 1'b0;
      tick_cnt_q <= 26'h0000000;
      dly_cnt_q <= 10'h000;
      silence_q <= 16'h0000;
    end else begin
      relay_q <= relay_d;
      cmd_q <= cmd_d;
      tick_cnt_q <= tick_cnt_d;
      dly_cnt_q <= dly_cnt_d;
      silence_q <= silence_d;
    end
  end

  // Checks
  logic thr_mode;
  assign thr_mode = (cfg_q.mode != MODE_BUS) && (cfg_q.mode != output_disabled);

  a_led_tracks_relay: assert property (@(posedge clk) disable iff (rst) led_on == relay_on)
    else $error("led differs from relay");
  a_disabled_stays_off: assert property (@(posedge clk) disable iff (rst)
    (cfg_q.mode == output_disabled && !(critical && cfg_q.fault_response == FAULT_FORCE_ON)) |=> !relay_q)
    else $error("relay on in disabled mode");
  a_force_on_wins: assert property (@(posedge clk) disable iff (rst)
    (critical && cfg_q.fault_response == FAULT_FORCE_ON) |=> relay_q)
    else $error("force-on not applied");
  a_force_off_wins: assert property (@(posedge clk) disable iff (rst)
    (critical && cfg_q.fault_response == FAULT_FORCE_OFF) |=> !relay_q)
    else $error("force-off not applied");
  a_fault_keeps: assert property (@(posedge clk) disable iff (rst)
    (critical && cfg_q.fault_response == keep_state) |=> $stable(relay_q))
    else $error("relay changed under keep response");
  a_bus_follows_cmd: assert property (@(posedge clk) disable iff (rst)
    (cfg_q.mode == MODE_BUS && !critical) |=> relay_q == $past(cmd_q))
    else $error("relay not following serial command");
  a_band_holds: assert property (@(posedge clk) disable iff (rst)
    (thr_mode && !critical && hold_band) |=> $stable(relay_q))
    else $error("relay changed inside band");
  a_on_delay_wait: assert property (@(posedge clk) disable iff (rst)
    (thr_mode && !critical && !relay_q && dly_cnt_q < cfg_q.turn_on_delay) |=> !relay_q)
    else $error("relay on before turn-on delay");
  a_off_delay_wait: assert property (@(posedge clk) disable iff (rst)
    (thr_mode && !critical && relay_q && dly_cnt_q < cfg_q.turn_off_delay) |=> relay_q)
    else $error("relay off before turn-off delay");
  a_thr_in_range: assert property (@(posedge clk) disable iff (rst)
    cfg_q.first_threshold >= THR_MIN && cfg_q.first_threshold <= THR_MAX &&
    cfg_q.second_threshold >= THR_MIN && cfg_q.second_threshold <= THR_MAX)
    else $error("threshold out of range");
  a_rx_clears_silence: assert property (@(posedge clk) disable iff (rst)
    (cfg_q.mode == MODE_BUS && serial_rx_pulse) |=> (cfg_q.mode != MODE_BUS || !critical))
    else $error("serial data did not clear timeout");
  // Zone checks use zero delays, so the decision must show at the next edge
  a_normal_above_on: assert property (@(posedge clk) disable iff (rst)
    (cfg_q.mode == MODE_NORMAL && !critical && cfg_q.turn_on_delay == 10'h000 && val > t1 + hw) |=> relay_q)
    else $error("relay not on above upper border");
  a_inside_zone_on: assert property (@(posedge clk) disable iff (rst)
    (cfg_q.mode == MODE_INSIDE && !critical && cfg_q.turn_on_delay == 10'h000 && val > lo + hw && val < hi - hw)
    |=> relay_q)
    else $error("relay not on inside window");
  a_outside_zone_off: assert property (@(posedge clk) disable iff (rst)
    (cfg_q.mode == MODE_OUTSIDE && !critical && cfg_q.turn_off_delay == 10'h000 && val > lo + hw && val < hi - hw)
    |=> !relay_q)
    else $error("relay not off inside window");
  a_idle_holds: assert property (@(posedge clk) disable iff (rst)
    (thr_mode && !critical && !pending) |=> $stable(relay_q))
    else $error("relay changed without pending switch");
  a_delay_restarts: assert property (@(posedge clk) disable iff (rst)
    !pending |=> dly_cnt_q == 10'h000)
    else $error("delay count not restarted");

  c_normal_on: cover property (@(posedge clk) disable iff (rst) cfg_q.mode == MODE_NORMAL && $rose(relay_q));
  c_window_on: cover property (@(posedge clk) disable iff (rst) cfg_q.mode == MODE_INSIDE && $rose(relay_q));
  c_bus_timeout: cover property (@(posedge clk) disable iff (rst) cfg_q.mode == MODE_BUS && $rose(critical));
  c_delayed_off: cover property (@(posedge clk) disable iff (rst) cfg_q.turn_off_delay != 10'h000 && $fell(relay_q));
  c_force_on_disabled: cover property (@(posedge clk) disable iff (rst) cfg_q.mode == output_disabled && critical && relay_q);

endmodule : relay_threshold_control

/* design/relay_pkg.sv */
/*
 * Constants, register map and types for the relay threshold controller.
 * Assumes a 10 MHz system clock and an AXI4-Lite master with 32-bit data.
 */
// Operation
// - Disabled mode keeps relay off unless a critical fault response forces it on or keeps it on.
// - Normal mode: on above first+half, off below first-half.
// - Inverted mode: off above first+half, on below first-half.
// - Inside window: on between lower+half and upper-half, off outside.
// - Outside window: on above upper+half or below lower-half, off inside.
// - Upper and lower thresholds found by comparison, any programming order.
// - Thresholds are signed, range -999 to 9999, centre of band.
// - Half-band is 0 to 999; total hysteresis is twice that.
// - Relay changes only outside threshold plus/minus half-band; holds inside.
// - Second threshold is used only by the window modes.
// - Bus mode sets relay only from serial commands, ignoring the value.
// - Serial-commanded relay state is volatile, cleared by reset.
// - Indicator LED lights exactly while the relay is closed.
// - Relay turns on only after on-condition lasts the turn-on delay.
// - Relay turns off only after off-condition lasts the turn-off delay.
// - Border crossings shorter than the delay leave the relay unchanged.
// - One bit selects seconds or minutes for both delays.
// - Critical situation applies fault response: keep, force on, force off.
// - Threshold modes treat over-range value as critical.
// - Bus mode is critical when serial silence exceeds the receive timeout; here silence stops counting while the unit bit selects minutes.
// - Force-on fault response energises relay even in disabled mode.
// - Comparison may use live value or held peak value.
// - Per-relay source bit picks live or held peak/drop value.
package relay_pkg;

  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] THR1_OFS = 8'h04;
  localparam logic [7:0] THR2_OFS = 8'h08;
  localparam logic [7:0] HALF_OFS = 8'h0C;
  localparam logic [7:0] TON_OFS = 8'h10;
  localparam logic [7:0] TURN_OFF_DELAY_OFS = 8'h14;
  localparam logic [7:0] TIMEOUT_OFS = 8'h18;
  localparam logic [7:0] STATUS_OFS = 8'h1C;

  // CTRL field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FAULT_LSB = 3;
  localparam int CTRL_UNIT_BIT = 5;
  localparam int CTRL_SRC_BIT = 6;

  localparam logic signed [15:0] THR_MIN = -16'sd999;
  localparam logic signed [15:0] THR_MAX = 16'sd9999;
  localparam logic [9:0] HALF_MAX = 10'h3E7;
  localparam logic [9:0] DELAY_MAX = 10'h3E7;

  localparam logic signed [15:0] THR_RESET = 16'sh0000;
  localparam logic [9:0] HALF_RESET = 10'h000;
  localparam logic [9:0] DELAY_RESET = 10'h000;
  localparam logic [15:0] TIMEOUT_RESET = 16'h0064;

  // Tick is one tenth of a second or of a minute
  localparam longint CLK_HZ = 10_000_000;
  localparam longint TENTH_SEC_MS = 100;
  localparam longint TENTH_MIN_MS = 6_000;
  localparam int TENTH_SEC_CYCLES = int'(TENTH_SEC_MS * CLK_HZ / 1000);
  localparam int TENTH_MIN_CYCLES = int'(TENTH_MIN_MS * CLK_HZ / 1000);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    output_disabled = 3'b000,
    MODE_NORMAL = 3'b001,
    MODE_INVERTED = 3'b010,
    MODE_INSIDE = 3'b011,
    MODE_OUTSIDE = 3'b100,
    MODE_BUS = 3'b101
  } relay_mode_t;

  typedef enum logic [1:0] {
    keep_state = 2'b00,
    FAULT_FORCE_ON = 2'b01,
    FAULT_FORCE_OFF = 2'b10
  } fault_resp_t;

  typedef struct packed {
    relay_mode_t mode;
    fault_resp_t fault_response;
    logic unit_minutes;
    logic relay_one_value_source;
    logic signed [15:0] first_threshold;
    logic signed [15:0] second_threshold;
    logic [9:0] band_half_width;
    logic [9:0] turn_on_delay;
    logic [9:0] turn_off_delay;
    logic [15:0] serial_receive_timeout;
  } relay_cfg_t;

  localparam relay_cfg_t CFG_RESET = '{output_disabled, keep_state, 1'b0, 1'b0, THR_RESET, THR_RESET,
                                       HALF_RESET, DELAY_RESET, DELAY_RESET, TIMEOUT_RESET};

endpackage : relay_pkg

/* tb/relay_load.sv */
/* Partner model: relay coil and contact set driven by the controller.
   Assumes the coil input comes straight from the controller's relay output. */
`timescale 1ns/1ns
module relay_load (
  input wire logic clk,
  input wire logic rst,
  input wire logic coil,
  output logic contact_q
);
  // Armature lags the coil by one clock, so a glitching coil shows up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      contact_q <= 1'b0;
    end else begin
      contact_q <= coil;
    end
  end
endmodule : relay_load

/* tb/relay_threshold_control_tb.sv */
/* Self-checking bench for relay_threshold_control: AXI4-Lite master tasks, step table, result watcher.
   Assumes the relay_pkg register map and a tick shortened to 10 clocks per tenth second. */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module relay_threshold_control_tb import relay_pkg::*;;
  typedef struct {logic [31:0] e; logic [31:0] m; logic [1:0] r;} rnote_t;
  typedef struct {logic [31:0] c; int t1; int t2; int v; logic o; logic e;} step_t;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, over, rx, cmd_v, cmd_on;
  logic awready, wready, bvalid, arready, rvalid, relay, led, contact_q;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] strb;
  logic [1:0] bresp, rresp;
  logic signed [15:0] live, peak;
  int num_errors, n_compared, v;
  rnote_t rq[$];
  logic [1:0] bq[$];
  step_t steps[$] = '{'{1, 100, -500, 111, 0, 1}, '{1, 100, -500, 110, 0, 1}, '{1, 100, -500, 89, 0, 0},
    '{1, 100, -500, 105, 0, 0}, '{2, 100, -500, 89, 0, 1}, '{2, 100, -500, 111, 0, 0},
    '{3, 200, 100, 150, 0, 1}, '{3, 200, 100, 215, 0, 0}, '{3, 200, 100, 205, 0, 0}, '{3, 100, 200, 150, 0, 1},
    '{3, 100, 200, 89, 0, 0}, '{4, 200, 100, 150, 0, 0}, '{4, 200, 100, 211, 0, 1}, '{4, 200, 100, 195, 0, 1},
    '{4, 100, 200, 150, 0, 0}, '{4, 100, 200, 89, 0, 1}, '{0, 100, 0, 500, 0, 0}, '{8, 100, 0, 500, 1, 1},
    '{8, 100, 0, 500, 0, 0}, '{1, 100, 0, 111, 0, 1}, '{1, 100, 0, 0, 1, 1}, '{17, 100, 0, 111, 1, 0},
    '{9, 100, 0, 0, 1, 1}, '{1, 100, 0, 0, 0, 0}, '{65, 100, 0, 0, 0, 1}, '{1, 100, 0, 0, 0, 0}};

  relay_threshold_control #(.TENTH_SEC_CYC(10), .TENTH_MIN_CYC(60)) u_dut (
    .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .live_value(live), .peak_value(peak),
    .value_over_range(over), .serial_rx_pulse(rx), .serial_cmd_valid(cmd_v), .serial_cmd_on(cmd_on),
    .relay_on(relay), .led_on(led));

  relay_load u_load (.clk(clk), .rst(rst), .coil(relay), .contact_q(contact_q));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Watcher: each handshake takes the oldest note off its queue
  always @(posedge clk) begin
    logic [1:0] eb;
    rnote_t n;
    if (bvalid && bready && bq.size() > 0) begin
      eb = bq.pop_front();
      `CHK("bresp", eb, bresp)
    end
    if (rvalid && rready && rq.size() > 0) begin
      n = rq.pop_front();
      `CHK("rdata", n.e, rdata & n.m)
      `CHK("rresp", n.r, rresp)
      `CHK("led", relay, led)
      `CHK("contact", relay, contact_q)
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tw, bd;
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      bd = bvalid;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!bd);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
    logic ta, rd_done;
    rq.push_back('{e, m, r});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ta = arvalid && arready;
      rd_done = rvalid;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end while (!rd_done);
  endtask : rd

  task automatic chk_relay(input logic e);
    rd(STATUS_OFS, {31'h0, e}, 32'h1, RESP_OKAY);
  endtask : chk_relay

  task automatic cmd(input logic on);
    rx <= 1'b1;
    cmd_v <= 1'b1;
    cmd_on <= on;
    @(posedge clk);
    rx <= 1'b0;
    cmd_v <= 1'b0;
    repeat (3) @(posedge clk);
    chk_relay(on);
  endtask : cmd

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    close_out();
  end

  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready, over, rx, cmd_v, cmd_on} = 10'h200;
    {awaddr, araddr, wdata} = '0;
    strb = 4'hF;
    live = '0;
    peak = 16'sd300;
    void'($urandom(32'hF459EDD2));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(8'(4 * i), (i == 6) ? 32'h64 : 32'h0, 32'hFFFFFFFF, RESP_OKAY);
    rd(8'h20, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    rd(8'h02, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    wr(8'h20, 32'h1, RESP_SLVERR);
    wr(STATUS_OFS, 32'hF, RESP_OKAY);
    chk_relay(1'b0);
    wr(THR1_OFS, 32'hFFFFF830, RESP_OKAY);
    rd(THR1_OFS, 32'hFFFFFC19, 32'hFFFFFFFF, RESP_OKAY);
    wr(THR2_OFS, 32'h4E20, RESP_OKAY);
    rd(THR2_OFS, 32'h270F, 32'hFFFFFFFF, RESP_OKAY);
    wr(HALF_OFS, 32'h7D0, RESP_OKAY);
    rd(HALF_OFS, 32'h3E7, 32'hFFFFFFFF, RESP_OKAY);
    wr(TON_OFS, 32'h1388, RESP_OKAY);
    rd(TON_OFS, 32'h3E7, 32'hFFFFFFFF, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      v = int'($urandom_range(10998)) - 999;
      wr(THR1_OFS, 32'(v), RESP_OKAY);
      rd(THR1_OFS, 32'(v), 32'hFFFFFFFF, RESP_OKAY);
    end
    wr(THR1_OFS, 32'h64, RESP_OKAY);
    strb <= 4'h2;
    wr(THR1_OFS, 32'h100, RESP_OKAY);
    strb <= 4'hF;
    rd(THR1_OFS, 32'h164, 32'hFFFFFFFF, RESP_OKAY);
    wr(CTRL_OFS, 32'h1, RESP_OKAY);
    wr(CTRL_OFS, 32'h6, RESP_OKAY);
    rd(CTRL_OFS, 32'h1, 32'hFFFFFFFF, RESP_OKAY);
    wr(TON_OFS, 32'h0, RESP_OKAY);
    wr(HALF_OFS, 32'hA, RESP_OKAY);
    foreach (steps[i]) begin
      wr(CTRL_OFS, steps[i].c, RESP_OKAY);
      wr(THR1_OFS, 32'(steps[i].t1), RESP_OKAY);
      wr(THR2_OFS, 32'(steps[i].t2), RESP_OKAY);
      live <= 16'(steps[i].v);
      over <= steps[i].o;
      repeat (3) @(posedge clk);
      chk_relay(steps[i].e);
    end
    wr(TON_OFS, 32'h5, RESP_OKAY);
    wr(TURN_OFF_DELAY_OFS, 32'h3, RESP_OKAY);
    live <= 16'sd111;
    repeat (30) @(posedge clk);
    live <= 16'sd0;
    repeat (5) @(posedge clk);
    live <= 16'sd111;
    repeat (30) @(posedge clk);
    live <= 16'sd0;
    repeat (20) @(posedge clk);
    chk_relay(1'b0);
    live <= 16'sd111;
    repeat (40) @(posedge clk);
    chk_relay(1'b0);
    repeat (20) @(posedge clk);
    chk_relay(1'b1);
    live <= 16'sd0;
    repeat (20) @(posedge clk);
    chk_relay(1'b1);
    repeat (20) @(posedge clk);
    chk_relay(1'b0);
    wr(CTRL_OFS, 32'h21, RESP_OKAY);
    wr(TON_OFS, 32'h2, RESP_OKAY);
    live <= 16'sd111;
    repeat (40) @(posedge clk);
    chk_relay(1'b0);
    repeat (90) @(posedge clk);
    chk_relay(1'b1);
    wr(TIMEOUT_OFS, 32'h3, RESP_OKAY);
    wr(CTRL_OFS, 32'h15, RESP_OKAY);
    live <= 16'sd500;
    cmd(1'b1);
    cmd(1'b0);
    live <= -16'sd900;
    cmd(1'b1);
    repeat (80) @(posedge clk);
    rd(STATUS_OFS, 32'h2, 32'h3, RESP_OKAY);
    cmd(1'b1);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(CTRL_OFS, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
    wr(CTRL_OFS, 32'h5, RESP_OKAY);
    rd(STATUS_OFS, 32'h0, 32'h9, RESP_OKAY);
    repeat (4) @(posedge clk);
    close_out();
  end
endmodule : relay_threshold_control_tb
